// ### rtl/slp_sequencer.sv
`timescale 1ns/100ps
//
// Behaviour
// RQ1: upper pending register shows sources seven to ten low, upper bits zero, read-only.
// RQ2: every reset source acts at once with equal top priority, no arbitration; the pin reset acts two cycles late, through its synchroniser.
// RQ3: break request forces the core to fetch the software trap vector.
// RQ4: in break, flag clearing elsewhere blocked unless clear permit bit set.
// RQ5: a flag cleared during permitted break clearing stays cleared after break.
// RQ6: two-step clears stay protected in break; second step after exit clears normally.
// RQ7: wait or stop instruction clears the global interrupt mask.
// RQ8: in wait the core clock stops, peripheral clocks keep running.
// RQ9: enabled interrupt wakes from wait; stacking starts one cycle later.
// RQ10: wait also ends on reset or break; break sets break-woke bit.
// RQ11: watchdog enabled and running in wait when watchdog disable is 0.
// RQ12: stop clears recovery counter and gates crystal and halved crystal clocks.
// RQ13: stop ends on interrupt, reset or break; stacking after recovery delay.
// RQ14: recovery is 4096 crystal cycles, or 32 when short recovery set.
// RQ15: software with an external crystal keeps short recovery clear.
// RQ16: recovery counter held cleared from stop until recovery begins, then counts.
// RQ17: break in stop sets break-woke; writing 0 clears it; reset clears it.
// RQ18: reading reset cause register clears all its flags.
// RQ19: power-on reset sets power-on flag and clears the others.
// RQ20: reset cause flags for pin, watchdog, bad opcode, bad fetch address.
// RQ21: clear permit bit read/write; 1 allows clearing in break, 0 prevents it.
// RQ22: flag seven timer overflow, eight sync processor, ten conversion complete.
// RQ23: break-woke and clear permit bits at fixed positions, other bits zero.
module slp_sequencer #(
    parameter int RECOVERY_LONG = slp_pkg::STOP_RECOVERY_LONG,
    parameter int RECOVERY_SHORT = slp_pkg::STOP_RECOVERY_SHORT
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic power_on_rst_in,
    input wire logic pin_rst_in,
    input wire logic watchdog_rst_in,
    input wire logic bad_opcode_rst_in,
    input wire logic bad_fetch_rst_in,
    input wire logic break_req_in,
    input wire logic wait_exec_in,
    input wire logic stop_exec_in,
    input wire logic irq_wake_in,
    input wire logic timer_overflow_irq_in,
    input wire logic sync_proc_irq_in,
    input wire logic source_nine_irq_in,
    input wire logic conversion_done_irq_in,
    input wire logic watchdog_disable_in,
    input wire logic short_stop_recovery_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic rd_in,
    input wire logic wr_in,
    output logic [7:0] rdata_out,
    output logic sys_reset_out,
    output logic trap_fetch_out,
    output logic break_state_out,
    output logic flag_clear_allowed_out,
    output logic clear_int_mask_out,
    output logic core_clk_en_out,
    output logic periph_clk_en_out,
    output logic crystal_clk_en_out,
    output logic halved_clk_en_out,
    output logic watchdog_run_out,
    output logic stack_start_out
);
    localparam int CW = 13;

    initial begin
        if (RECOVERY_SHORT < 2 * slp_pkg::XTAL_PER_BUS || RECOVERY_LONG >= (1 << CW)
                || RECOVERY_SHORT > RECOVERY_LONG) begin
            $error("slp_sequencer: recovery counts out of range");
        end
    end

    // ==========================================================
    // pin synchroniser
    // ==========================================================
    logic pin_meta_r;
    logic pin_sync_r;
    logic pin_meta_nxt;
    logic pin_sync_nxt;

    always_comb begin
        pin_meta_nxt = pin_rst_in;
        pin_sync_nxt = pin_meta_r;
    end

    always_ff @(posedge core_clk_in) begin
        pin_meta_r <= pin_meta_nxt;
        pin_sync_r <= pin_sync_nxt;
    end

    // ==========================================================
    // reset combining
    // ==========================================================
    logic any_rst;
    assign any_rst = rst_in | power_on_rst_in | pin_sync_r | watchdog_rst_in
        | bad_opcode_rst_in | bad_fetch_rst_in; // [RQ2]

    // ==========================================================
    // register state
    // ==========================================================
    slp_pkg::slp_state_t state_r;
    slp_pkg::slp_state_t state_nxt;
    logic break_woke_r;
    logic break_woke_nxt;
    logic clear_permit_r;
    logic clear_permit_nxt;
    logic [7:0] cause_r;
    logic [7:0] cause_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic in_break_r;
    logic in_break_nxt;
    logic trap_r;
    logic trap_nxt;
    logic mask_clr_r;
    logic mask_clr_nxt;
    logic stack_r;
    logic stack_nxt;
    logic rec_done;
    logic [3:0] upper_flags;
    logic woke_set;

    // a break that ends wait or stop this cycle; it outranks a clearing write
    assign woke_set = break_req_in && (state_r == slp_pkg::SLP_WAIT || state_r == slp_pkg::SLP_STOP);

    assign upper_flags = {conversion_done_irq_in, source_nine_irq_in,
        sync_proc_irq_in, timer_overflow_irq_in}; // [RQ22]

    // recovery counter: held cleared outside recovery, counts crystal cycles
    slp_recovery_counter #(
        .WIDTH(CW)
    ) u_recovery (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .hold_in(state_r != slp_pkg::SLP_RECOVER), // [RQ16] [RQ12]
        .step_in(CW'(slp_pkg::XTAL_PER_BUS)),
        .limit_in(short_stop_recovery_in ? CW'(RECOVERY_SHORT) : CW'(RECOVERY_LONG)), // [RQ14]
        .done_out(rec_done)
    );

    // ==========================================================
    // power sequencing, break and registers: next values
    // ==========================================================
    always_comb begin
        state_nxt = state_r;
        break_woke_nxt = break_woke_r;
        clear_permit_nxt = clear_permit_r;
        cause_nxt = cause_r;
        rdata_nxt = rdata_r;
        in_break_nxt = in_break_r;
        trap_nxt = 1'b0;
        mask_clr_nxt = 1'b0;
        stack_nxt = 1'b0;
        // power and break sequencing
        unique case (state_r)
            slp_pkg::SLP_RUN: begin
                if (wait_exec_in) begin
                    state_nxt = slp_pkg::SLP_WAIT;
                    mask_clr_nxt = 1'b1; // [RQ7]
                end else if (stop_exec_in) begin
                    state_nxt = slp_pkg::SLP_STOP;
                    mask_clr_nxt = 1'b1; // [RQ7]
                end
            end
            slp_pkg::SLP_WAIT: begin
                if (break_req_in) begin
                    state_nxt = slp_pkg::SLP_RUN;
                    break_woke_nxt = 1'b1; // [RQ10]
                end else if (irq_wake_in) begin
                    state_nxt = slp_pkg::SLP_RUN;
                    stack_nxt = 1'b1; // [RQ9]
                end
            end
            slp_pkg::SLP_STOP: begin
                if (break_req_in) begin
                    state_nxt = slp_pkg::SLP_RECOVER;
                    break_woke_nxt = 1'b1; // [RQ17]
                end else if (irq_wake_in) begin
                    state_nxt = slp_pkg::SLP_RECOVER; // [RQ13]
                end
            end
            slp_pkg::SLP_RECOVER: begin
                if (rec_done) begin
                    state_nxt = slp_pkg::SLP_RUN;
                    stack_nxt = 1'b1; // [RQ13]
                end
            end
        endcase
        // break entry forces the trap vector, outside stop recovery
        if (break_req_in && !in_break_r && state_nxt != slp_pkg::SLP_RECOVER) begin
            in_break_nxt = 1'b1;
            trap_nxt = 1'b1; // [RQ3]
        end else if (!break_req_in && state_r == slp_pkg::SLP_RUN) begin
            in_break_nxt = 1'b0;
        end
        // register writes
        if (wr_in && addr_in == slp_pkg::ADDR_BREAK_WAKE_STATUS && !wdata_in[slp_pkg::BIT_BREAK_WOKE]
                && !woke_set) begin
            break_woke_nxt = 1'b0; // [RQ17]
        end
        if (wr_in && addr_in == slp_pkg::ADDR_BREAK_FLAG_CONTROL) begin
            clear_permit_nxt = wdata_in[slp_pkg::BIT_FLAG_CLEAR_PERMIT]; // [RQ21]
        end
        // register reads; reset cause clears on read
        rdata_nxt = slp_pkg::RESET_BYTE;
        if (rd_in) begin
            unique case (addr_in)
                slp_pkg::ADDR_BREAK_WAKE_STATUS: rdata_nxt[slp_pkg::BIT_BREAK_WOKE] = break_woke_r; // [RQ23]
                slp_pkg::ADDR_RESET_CAUSE_STATUS: begin
                    rdata_nxt = cause_r;
                    cause_nxt = slp_pkg::RESET_BYTE; // [RQ18]
                end
                slp_pkg::ADDR_BREAK_FLAG_CONTROL: begin
                    rdata_nxt[slp_pkg::BIT_FLAG_CLEAR_PERMIT] = clear_permit_r; // [RQ21]
                end
                slp_pkg::ADDR_INTERRUPT_PENDING_UPPER: begin
                    rdata_nxt[slp_pkg::UPPER_FLAG_COUNT-1:0] = upper_flags; // [RQ1]
                end
                default: rdata_nxt = slp_pkg::RESET_BYTE;
            endcase
        end
    end

    // ==========================================================
    // registers; every reset source acts at once except the pin, two cycles late through its synchroniser
    // ==========================================================
    always_ff @(posedge core_clk_in) begin
        if (any_rst) begin // [RQ2]
            state_r <= slp_pkg::SLP_RUN; // [RQ10] [RQ13]
            break_woke_r <= 1'b0; // [RQ17]
            clear_permit_r <= 1'b0;
            rdata_r <= slp_pkg::RESET_BYTE;
            in_break_r <= 1'b0;
            trap_r <= 1'b0;
            mask_clr_r <= 1'b0;
            stack_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            break_woke_r <= break_woke_nxt;
            clear_permit_r <= clear_permit_nxt;
            rdata_r <= rdata_nxt;
            in_break_r <= in_break_nxt;
            trap_r <= trap_nxt;
            mask_clr_r <= mask_clr_nxt;
            stack_r <= stack_nxt;
        end
    end

    // reset cause capture: power-on wins and clears the rest
    always_ff @(posedge core_clk_in) begin
        if (power_on_rst_in) begin
            cause_r <= 8'(1 << slp_pkg::BIT_POWER_ON_CAUSE); // [RQ19]
        end else if (any_rst) begin
            cause_r <= cause_r | ({7'h00, pin_sync_r} << slp_pkg::BIT_PIN_CAUSE)
                | ({7'h00, watchdog_rst_in} << slp_pkg::BIT_WATCHDOG_CAUSE)
                | ({7'h00, bad_opcode_rst_in} << slp_pkg::BIT_BAD_OPCODE_CAUSE)
                | ({7'h00, bad_fetch_rst_in} << slp_pkg::BIT_BAD_FETCH_CAUSE); // [RQ20]
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // ==========================================================
    // registered outputs
    // ==========================================================
    logic rst_out_r;
    logic core_en_r;
    logic periph_en_r;
    logic xtal_en_r;
    logic wdog_r;
    logic permit_out_r;

    always_ff @(posedge core_clk_in) begin
        rst_out_r <= any_rst;
        core_en_r <= (state_nxt == slp_pkg::SLP_RUN) | any_rst; // [RQ8]
        periph_en_r <= (state_nxt != slp_pkg::SLP_STOP) | any_rst; // [RQ8] [RQ12]
        xtal_en_r <= (state_nxt != slp_pkg::SLP_STOP) | any_rst; // [RQ12]
        wdog_r <= ~watchdog_disable_in; // [RQ11]
        permit_out_r <= ~in_break_nxt | clear_permit_nxt | any_rst; // [RQ4] [RQ5] [RQ6]
    end

    assign rdata_out = rdata_r;
    assign sys_reset_out = rst_out_r;
    assign trap_fetch_out = trap_r;
    assign break_state_out = in_break_r;
    assign flag_clear_allowed_out = permit_out_r;
    assign clear_int_mask_out = mask_clr_r;
    assign core_clk_en_out = core_en_r;
    assign periph_clk_en_out = periph_en_r;
    assign crystal_clk_en_out = xtal_en_r;
    assign halved_clk_en_out = xtal_en_r;
    assign watchdog_run_out = wdog_r;
    assign stack_start_out = stack_r;
endmodule

// ### rtl/slp_pkg.sv
package slp_pkg;
    // ==========================================================
    // register map (byte addresses on the core bus)
    // ==========================================================
    localparam logic [15:0] ADDR_BREAK_WAKE_STATUS = 16'hfe00;
    localparam logic [15:0] ADDR_RESET_CAUSE_STATUS = 16'hfe01;
    localparam logic [15:0] ADDR_BREAK_FLAG_CONTROL = 16'hfe03;
    localparam logic [15:0] ADDR_INTERRUPT_PENDING_UPPER = 16'hfe05;

    // ==========================================================
    // field positions
    // ==========================================================
    localparam int BIT_BREAK_WOKE = 1;
    localparam int BIT_FLAG_CLEAR_PERMIT = 7;
    localparam int BIT_POWER_ON_CAUSE = 7;
    localparam int BIT_PIN_CAUSE = 6;
    localparam int BIT_WATCHDOG_CAUSE = 5;
    localparam int BIT_BAD_OPCODE_CAUSE = 4;
    localparam int BIT_BAD_FETCH_CAUSE = 3;
    localparam int UPPER_FLAG_COUNT = 4;

    // ==========================================================
    // reset values and timing
    // ==========================================================
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int STOP_RECOVERY_LONG = 4096;
    localparam int STOP_RECOVERY_SHORT = 32;
    localparam int XTAL_PER_BUS = 4;

    // ==========================================================
    // power states
    // ==========================================================
    typedef enum logic [1:0] {
        SLP_RUN,
        SLP_WAIT,
        SLP_STOP,
        SLP_RECOVER
    } slp_state_t;
endpackage

// ### rtl/slp_recovery_counter.sv
`timescale 1ns/100ps
// counts crystal clock cycles while enabled, held cleared otherwise
module slp_recovery_counter #(
    parameter int WIDTH = 13
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic hold_in,
    input wire logic [WIDTH-1:0] step_in,
    input wire logic [WIDTH-1:0] limit_in,
    output logic done_out
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic done_r;
    logic done_nxt;

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        count_nxt = count_r;
        done_nxt = 1'b0;
        if (hold_in) begin
            count_nxt = '0;
        end else if (count_r >= limit_in - step_in) begin
            done_nxt = 1'b1;
        end else begin
            count_nxt = count_r + step_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            count_r <= '0;
            done_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            done_r <= done_nxt;
        end
    end

    assign done_out = done_r;
endmodule

// ### testbench/slp_periph_model.sv
`timescale 1ns/100ps
// ==========================================================
// peripheral side: interrupt sources and one wake request
// ==========================================================
module slp_periph_model (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [3:0] src_cmd_in,
    input wire logic wake_cmd_in,
    input wire logic [7:0] wake_delay_in,
    input wire logic stack_start_in,
    output logic [3:0] src_out,
    output logic wake_out
);
    logic [7:0] cnt_r;
    // wake rises after the chosen latency, drops once stacking starts
    always_ff @(posedge core_clk_in) begin
        src_out <= src_cmd_in;
        if (rst_in || !wake_cmd_in || stack_start_in) begin
            cnt_r <= 8'h00;
            wake_out <= 1'b0;
        end else if (cnt_r >= wake_delay_in) begin
            wake_out <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule

// ### testbench/slp_sequencer_chk.sv
`timescale 1ns/100ps
// ==========================================================
// port checker for the sequencer
// ==========================================================
module slp_sequencer_chk (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic break_req_in,
    input wire logic wait_exec_in,
    input wire logic stop_exec_in,
    input wire logic irq_wake_in,
    input wire logic timer_overflow_irq_in,
    input wire logic sync_proc_irq_in,
    input wire logic source_nine_irq_in,
    input wire logic conversion_done_irq_in,
    input wire logic watchdog_disable_in,
    input wire logic [15:0] addr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic sys_reset_out,
    input wire logic trap_fetch_out,
    input wire logic break_state_out,
    input wire logic flag_clear_allowed_out,
    input wire logic clear_int_mask_out,
    input wire logic core_clk_en_out,
    input wire logic periph_clk_en_out,
    input wire logic crystal_clk_en_out,
    input wire logic halved_clk_en_out,
    input wire logic watchdog_run_out,
    input wire logic stack_start_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    logic stop_pend_r;
    logic stop_pend_nxt;
    // remembers a stop until the core clock returns, so recovery is not taken for wait
    always_comb begin
        stop_pend_nxt = stop_pend_r;
        if (sys_reset_out) begin
            stop_pend_nxt = 1'b0;
        end else if (stop_exec_in) begin
            stop_pend_nxt = 1'b1;
        end else if (core_clk_en_out) begin
            stop_pend_nxt = 1'b0;
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            stop_pend_r <= 1'b0;
        end else begin
            stop_pend_r <= stop_pend_nxt;
        end
    end
    chk_upper_read: assert property (rd_in && addr_in == slp_pkg::ADDR_INTERRUPT_PENDING_UPPER |=>
        rdata_out == {4'h0, $past(conversion_done_irq_in), $past(source_nine_irq_in),
        $past(sync_proc_irq_in), $past(timer_overflow_irq_in)}) else $error("upper pending read wrong");
    chk_reset_clocks: assert property (sys_reset_out |-> core_clk_en_out && periph_clk_en_out
        && !stack_start_out) else $error("reset did not take over");
    chk_trap_pulse: assert property ($rose(break_req_in) && core_clk_en_out && !sys_reset_out |=>
        trap_fetch_out ##1 !trap_fetch_out) else $error("trap fetch pulse wrong");
    chk_permit_gate: assert property (!sys_reset_out && !break_state_out |->
        flag_clear_allowed_out) else $error("flag clearing blocked outside break");
    chk_mask_clear: assert property (wait_exec_in || stop_exec_in |=>
        clear_int_mask_out) else $error("interrupt mask not cleared");
    chk_wait_clocks: assert property (wait_exec_in |=> !core_clk_en_out && periph_clk_en_out)
        else $error("wait clock gating wrong");
    chk_wait_wake: assert property (!core_clk_en_out && periph_clk_en_out && irq_wake_in
        && !break_req_in && !stop_pend_r |=> stack_start_out && core_clk_en_out) else $error("wait wake late");
    chk_watchdog_wait: assert property (!watchdog_disable_in && wait_exec_in |=>
        watchdog_run_out [*2]) else $error("watchdog halted in wait");
    chk_stop_clocks: assert property (stop_exec_in |=> !(core_clk_en_out | periph_clk_en_out
        | crystal_clk_en_out | halved_clk_en_out)) else $error("stop clocks still on");
    cover property (stack_start_out);
    cover property (trap_fetch_out);
    cover property (break_state_out && flag_clear_allowed_out);
endmodule
bind slp_sequencer slp_sequencer_chk i_chk (.*);

// ### testbench/slp_sequencer_bench.sv
`timescale 1ns/100ps
// ==========================================================
// testbench top
// ==========================================================
module slp_sequencer_bench;
    localparam int LONG = 64;
    localparam int SHORT = 32;
    localparam logic [15:0] A_BWS = slp_pkg::ADDR_BREAK_WAKE_STATUS;
    localparam logic [15:0] A_CAUSE = slp_pkg::ADDR_RESET_CAUSE_STATUS;
    localparam logic [15:0] A_BFC = slp_pkg::ADDR_BREAK_FLAG_CONTROL;
    localparam logic [15:0] A_UP = slp_pkg::ADDR_INTERRUPT_PENDING_UPPER;
    logic clk = 1'b0, rst = 1'b1, por = 1'b1, pin = 1'b0, wdog = 1'b0, bop = 1'b0, bfe = 1'b0;
    logic brk = 1'b0, wai = 1'b0, stp = 1'b0, wdis = 1'b0, ssr = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdat = 8'h00, rdata, wdly = 8'h00;
    logic [3:0] src_cmd = 4'h0, src;
    logic wake_cmd = 1'b0, wake, sysr, trap, brks, allow, mclr, cen, pen, xen, hen, wrun, stk;
    int n_fail = 0, tests_run = 0, cyc = 0, n, exp;
    // bus clock
    always #20 clk = ~clk;
    slp_sequencer #(.RECOVERY_LONG(LONG), .RECOVERY_SHORT(SHORT)) i_dut (
        .core_clk_in(clk), .rst_in(rst), .power_on_rst_in(por), .pin_rst_in(pin),
        .watchdog_rst_in(wdog), .bad_opcode_rst_in(bop), .bad_fetch_rst_in(bfe), .break_req_in(brk),
        .wait_exec_in(wai), .stop_exec_in(stp), .irq_wake_in(wake), .timer_overflow_irq_in(src[0]),
        .sync_proc_irq_in(src[1]), .source_nine_irq_in(src[2]), .conversion_done_irq_in(src[3]),
        .watchdog_disable_in(wdis), .short_stop_recovery_in(ssr), .addr_in(addr), .wdata_in(wdat),
        .rd_in(rd), .wr_in(wr), .rdata_out(rdata), .sys_reset_out(sysr), .trap_fetch_out(trap),
        .break_state_out(brks), .flag_clear_allowed_out(allow), .clear_int_mask_out(mclr),
        .core_clk_en_out(cen), .periph_clk_en_out(pen), .crystal_clk_en_out(xen),
        .halved_clk_en_out(hen), .watchdog_run_out(wrun), .stack_start_out(stk));
    slp_periph_model i_periph (.core_clk_in(clk), .rst_in(rst), .src_cmd_in(src_cmd),
        .wake_cmd_in(wake_cmd), .wake_delay_in(wdly), .stack_start_in(stk), .src_out(src), .wake_out(wake));
    // ======================================================
    // helpers
    // ======================================================
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask
    // expected bus cycles of stop recovery for the chosen delay
    function automatic int rec_cycles(input logic short_sel);
        return (short_sel ? SHORT : LONG) / slp_pkg::XTAL_PER_BUS;
    endfunction
    // read data stands one cycle after the strobe; an idle cycle follows each access
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] want);
        addr = a;
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        chk(rdata, want);
        tick(1);
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        addr = a;
        wdat = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask
    task automatic wait_stack();
        n = 0;
        while (stk !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    // ======================================================
    // scenarios
    // ======================================================
    initial begin
        void'($urandom(91));
        tick(16);
        rst = 1'b0;
        por = 1'b0;
        tick(2);
        rd_reg(A_CAUSE, 8'h80);
        rd_reg(A_CAUSE, 8'h00);
        // each other source leaves only its own cause bit
        for (int i = 0; i < 4; i++) begin
            {pin, wdog, bop, bfe} = 4'b1000 >> i;
            tick(4);
            chk({7'h00, sysr}, 8'h01);
            {pin, wdog, bop, bfe} = 4'h0;
            tick(4);
            rd_reg(A_CAUSE, 8'h40 >> i);
        end
        // upper pending flags follow the sources, writes ignored
        for (int i = 0; i < 8; i++) begin
            src_cmd = (i == 0) ? 4'hf : 4'($urandom);
            tick(3);
            rd_reg(A_UP, {4'h0, src_cmd});
            wr_reg(A_UP, 8'hff);
            rd_reg(A_UP, {4'h0, src_cmd});
        end
        rd_reg(16'hfe02, 8'h00);
        wr_reg(A_BFC, 8'hff);
        rd_reg(A_BFC, 8'h80);
        wr_reg(A_BFC, 8'h00);
        // break with clearing blocked, then permitted, then left
        brk = 1'b1;
        tick(3);
        chk({6'h00, brks, allow}, 8'h02);
        wr_reg(A_BFC, 8'h80);
        tick(1);
        chk({6'h00, brks, allow}, 8'h03);
        brk = 1'b0;
        wr_reg(A_BFC, 8'h00);
        tick(3);
        chk({6'h00, brks, allow}, 8'h01);
        // wait, woken by a slow interrupt
        wai = 1'b1;
        tick(1);
        wai = 1'b0;
        chk({4'h0, cen, pen, mclr, wrun}, 8'h07);
        wdly = 8'h05;
        wake_cmd = 1'b1;
        wait_stack();
        wake_cmd = 1'b0;
        chk({7'h00, cen}, 8'h01);
        // watchdog follows its disable option
        wdis = 1'b1;
        tick(2);
        chk({7'h00, wrun}, 8'h00);
        wdis = 1'b0;
        tick(2);
        chk({7'h00, wrun}, 8'h01);
        // wait left by break, then status cleared by writing zero
        wai = 1'b1;
        tick(1);
        wai = 1'b0;
        tick(2);
        brk = 1'b1;
        tick(4);
        brk = 1'b0;
        tick(3);
        rd_reg(A_BWS, 8'h02);
        wr_reg(A_BWS, 8'h00);
        rd_reg(A_BWS, 8'h00);
        // stop with long then short recovery, prompt random wake
        for (int k = 0; k < 2; k++) begin
            ssr = k[0]; // long recovery first, as crystal systems keep it
            stp = 1'b1;
            tick(1);
            stp = 1'b0;
            tick(10);
            chk({4'h0, cen, pen, xen, hen}, 8'h00);
            wdly = 8'($urandom_range(0, 3));
            wake_cmd = 1'b1;
            wait_stack();
            wake_cmd = 1'b0;
            exp = rec_cycles(k[0]);
            chk({7'h00, n >= exp && n <= exp + 8}, 8'h01);
        end
        // break ends stop and sets the status, a reset on rst clears it
        stp = 1'b1;
        tick(1);
        stp = 1'b0;
        tick(3);
        brk = 1'b1;
        tick(20);
        brk = 1'b0;
        tick(3);
        rd_reg(A_BWS, 8'h02);
        rst = 1'b1;
        tick(1);
        rst = 1'b0;
        tick(2);
        rd_reg(A_BWS, 8'h00);
        close_out();
    end
endmodule
